// file: rtl/atm_card.sv
`timescale 1ns/1ps
`default_nettype none
`include "atm_consts.svh"

module atm_fifo #(
	parameter int W = 8,
	parameter int D = `ATM_FIFO_DEPTH
) (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	input wire logic flush, // drop contents
	input wire logic [W-1:0] in_data, // write data
	input wire logic in_valid, // write valid
	output logic in_ready, // not full
	output logic [W-1:0] out_data, // head word
	output logic out_valid, // not empty
	input wire logic out_ready // pop
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} atm_fifo_t;
	atm_fifo_t s_reg, s_next;
	logic push, pop;
	assign in_ready = s_reg.cnt != (AW+1)'(D);
	assign out_valid = s_reg.cnt != '0;
	assign out_data = s_reg.mem[s_reg.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = (s_reg.wp == AW'(D-1)) ? '0 : s_reg.wp + 1'b1;
		end
		if (pop)
			s_next.rp = (s_reg.rp == AW'(D-1)) ? '0 : s_reg.rp + 1'b1;
		s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			s_next.wp = '0;
			s_next.rp = '0;
			s_next.cnt = '0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
endmodule : atm_fifo

////////////////////////////////////////////////////////////////////////////////

module atm_card #(
	parameter int IFS = `ATM_IFS
) (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	atm_link_if.card link, // to terminal
	output logic cmd_rdy, // header or whole T=1 message in
	output logic [39:0] cmd_hdr, // T=0 header
	output logic [7:0] cmd_data, // command byte
	output logic cmd_dv, // command byte strobe
	input wire logic app_go, // answer valid
	input wire atm_pkg::atm_case_t app_case, // command case
	input wire logic [8:0] app_luicc, // bytes available
	input wire logic [15:0] app_sw, // status
	input wire logic app_ok, // normal processing
	input wire logic [7:0] rd_data, // response data
	input wire logic rd_valid, // response data valid
	output logic rd_ready, // fifo has room
	output logic done // status sent
);
	import atm_pkg::*;
	typedef struct packed {
		atm_card_st_t st;
		logic [39:0] hdr;
		logic [2:0] hc;
		logic [8:0] cnt;
		logic [8:0] le;
		logic [8:0] lu;
		logic [8:0] pend;
		logic [8:0] rem;
		logic [8:0] bc;
		logic [15:0] sw;
		atm_case_t cs;
		logic ok;
		logic gr;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] tx;
		logic txv;
		logic txl;
		logic txm;
		logic [7:0] cd;
		logic cdv;
		logic rdy;
		logic done;
		logic flush;
	} atm_card_t;
	atm_card_t s_reg, s_next;
	logic [7:0] ff_data;
	logic ff_valid, ff_pop, free, t1, blk_end;
	logic [39:0] hn;

	function automatic logic [15:0] fix_sw(input logic [15:0] sw);
		fix_sw = (sw == `ATM_SW_OK) ? `ATM_SW_FALLBACK : sw;
	endfunction : fix_sw

	function automatic logic data_sw(input logic [15:0] sw);
		data_sw = sw[15:8] == `ATM_SW_WARN1 || sw[15:8] == `ATM_SW_WARN2 ||
			sw[15:12] == `ATM_SW_APP;
	endfunction : data_sw

	atm_fifo #(.W(8), .D(`ATM_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.flush(s_reg.flush),
		.in_data(rd_data),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.out_data(ff_data),
		.out_valid(ff_valid),
		.out_ready(ff_pop)
	);

	assign t1 = link.t1_mode;
	assign free = !s_reg.txv || link.c2t_ready;
	assign blk_end = s_reg.bc == 9'(IFS - 1);
	assign hn = {s_reg.hdr[31:0], link.t2c_data};
	assign link.t2c_ready = (s_reg.st == CS_IDLE) || (s_reg.st == CS_DIN);
	assign link.c2t_data = s_reg.tx;
	assign link.c2t_valid = s_reg.txv;
	assign link.c2t_last = s_reg.txl;
	assign link.c2t_more = s_reg.txm;
	assign cmd_rdy = s_reg.rdy;
	assign cmd_hdr = s_reg.hdr;
	assign cmd_data = s_reg.cd;
	assign cmd_dv = s_reg.cdv;
	assign done = s_reg.done;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic go, load;
		logic [7:0] b;
		logic [8:0] lu;
		logic [15:0] sw;
		atm_case_t c;
		go = 1'b0;
		load = 1'b0;
		b = 8'h00;
		lu = s_reg.lu;
		sw = s_reg.sw;
		c = s_reg.cs;
		ff_pop = 1'b0;
		s_next = s_reg;
		s_next.rdy = 1'b0;
		s_next.cdv = 1'b0;
		s_next.done = 1'b0;
		s_next.flush = 1'b0;
		if (s_reg.txv && link.c2t_ready)
			s_next.txv = 1'b0;
		case (s_reg.st)
			CS_IDLE: begin
				if (link.t2c_valid) begin
					if (t1) begin
						s_next.cd = link.t2c_data;
						s_next.cdv = 1'b1;
						if (link.t2c_last && !link.t2c_more) begin
							s_next.rdy = 1'b1;
							s_next.flush = 1'b1;
							s_next.st = CS_ASK;
						end
					end else begin
						s_next.hdr = hn;
						s_next.hc = s_reg.hc + 3'h1;
						if (s_reg.hc == 3'h4) begin
							s_next.hc = 3'h0;
							s_next.le = (hn[7:0] == 8'h00) ? `ATM_LEN_FULL : {1'b0, hn[7:0]};
							s_next.st = CS_ASK;
							if (hn[31:24] == `ATM_INS_GR && s_reg.pend != 9'h000) begin
								s_next.gr = 1'b1;
								s_next.cs = ATM_C2;
								s_next.lu = s_reg.pend;
								s_next.sw = `ATM_SW_OK;
								s_next.ok = 1'b1;
							end else begin
								s_next.gr = 1'b0;
								s_next.pend = 9'h000;
								s_next.rdy = 1'b1;
								s_next.flush = 1'b1;
							end
						end
					end
				end
			end
			CS_ASK: begin
				go = (s_reg.gr || app_go) && free;
				if (!s_reg.gr) begin
					c = app_case;
					lu = app_luicc;
					sw = app_sw;
				end
				if (go) begin
					s_next.cs = c;
					s_next.lu = lu;
					s_next.sw = sw;
					s_next.ok = s_reg.gr || app_ok;
					if (t1) begin
						// cases 1 and 3 carry no response data
						s_next.rem = ((data_sw(sw) && (c == ATM_C2 || c == ATM_C4)) ? lu : 9'h000) +
							9'h002;
						s_next.bc = 9'h000;
						s_next.st = CS_DOUT;
					end else begin
						s_next.st = CS_SW1;
						case (c)
							ATM_C3, ATM_C4: begin
								if (app_ok) begin
									load = 1'b1;
									b = s_reg.hdr[31:24];
									s_next.cnt = s_reg.le;
									s_next.st = CS_DIN;
								end else if (c == ATM_C4)
									s_next.sw = fix_sw(sw);
							end
							ATM_C2: begin
								if (!(s_reg.gr || app_ok))
									s_next.sw = fix_sw(sw);
								else if ((s_reg.le == `ATM_LEN_FULL && lu != `ATM_LEN_FULL) ||
									s_reg.le > lu) begin
									s_next.p1 = `ATM_PB_RETRY;
									s_next.p2 = lu[7:0];
									s_next.st = CS_PB1;
								end else begin
									load = 1'b1;
									b = s_reg.hdr[31:24];
									s_next.cnt = s_reg.le;
									s_next.rem = lu - s_reg.le;
									s_next.st = CS_DOUT;
								end
							end
							default: ;
						endcase
					end
				end
			end
			CS_DIN: begin
				if (link.t2c_valid) begin
					s_next.cd = link.t2c_data;
					s_next.cdv = 1'b1;
					s_next.cnt = s_reg.cnt - 9'h001;
					if (s_reg.cnt == 9'h001) begin
						s_next.st = CS_SW1;
						if (s_reg.cs == ATM_C4) begin
							s_next.p1 = `ATM_PB_GET;
							s_next.p2 = s_reg.lu[7:0];
							s_next.pend = s_reg.lu;
							s_next.st = CS_PB1;
						end
					end
				end
			end
			CS_DOUT: begin
				if (t1) begin
					if (s_reg.rem == 9'h002)
						s_next.st = CS_SW1;
					else if (free && ff_valid) begin
						ff_pop = 1'b1;
						load = 1'b1;
						b = ff_data;
					end
				end else if (free && ff_valid) begin
					ff_pop = 1'b1;
					load = 1'b1;
					b = ff_data;
					s_next.cnt = s_reg.cnt - 9'h001;
					if (s_reg.cnt == 9'h001) begin
						s_next.st = CS_SW1;
						if (s_reg.rem != 9'h000) begin
							s_next.p1 = `ATM_PB_GET;
							s_next.p2 = s_reg.rem[7:0];
							s_next.pend = s_reg.rem;
							s_next.st = CS_PB1;
						end
					end
				end
			end
			CS_SW1: begin
				if (free) begin
					load = 1'b1;
					b = s_reg.sw[15:8];
					s_next.st = CS_SW2;
				end
			end
			CS_SW2: begin
				if (free) begin
					load = 1'b1;
					b = s_reg.sw[7:0];
					s_next.pend = 9'h000;
					s_next.done = 1'b1;
					s_next.st = CS_IDLE;
				end
			end
			CS_PB1: begin
				if (free) begin
					load = 1'b1;
					b = s_next.hc == 3'h0 ? s_reg.p1 : s_reg.p2;
					s_next.hc = s_reg.hc + 3'h1;
					if (s_reg.hc == 3'h1) begin
						s_next.hc = 3'h0;
						s_next.st = CS_IDLE;
					end
				end
			end
			default: s_next.st = CS_IDLE;
		endcase
		if (load) begin
			s_next.tx = b;
			s_next.txv = 1'b1;
			s_next.txl = 1'b0;
			s_next.txm = 1'b0;
			if (t1) begin
				s_next.txl = blk_end || s_reg.rem == 9'h001;
				s_next.txm = blk_end && s_reg.rem != 9'h001;
				s_next.bc = blk_end ? 9'h000 : s_reg.bc + 9'h001;
				s_next.rem = s_reg.rem - 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.st <= CS_IDLE;
			s_reg.cs <= ATM_C1;
		end else
			s_reg <= s_next;
	end
endmodule : atm_card
`default_nettype wire

// file: rtl/atm_consts.svh
// Contract
// - T=0 case 4 drops Le, P3 equals Lc
// - command data only after procedure byte; status aborts
// - case 4 data answered 61xx, else status
// - after 61xx, GET RESPONSE P3 at most xx
// - case 4 warning/9xxx status: GET RESPONSE Le=00
// - other case 4 status ends command
// - GET RESPONSE treated as case 2
// - 61xx/6Cxx only for T=0 cases 2, 4
// - 6Cxx: resend header with P3=xx
// - error status may replace 61xx/6Cxx
// - short or oversize Le: 6C Luicc or error (code: Le below Luicc gets data then 61 remainder)
// - exact Le: data then status
// - Le below Luicc: data then 61 remainder
// - case 4 answer 61xx or non-9000 status
// - T=1 messages carried unchanged in I-blocks
// - T=1 data only with 62/63/9xxx status
// - T=1 case 2 response concatenates chained blocks
// - T=1 long commands and responses chained
// - T=1 case 1 response passed unchanged
// - case 4 first answer announces pending length
// - terminal ends on status, not procedure bytes
// - chained blocks full size except last
`ifndef ATM_CONSTS_SVH
`define ATM_CONSTS_SVH
`define ATM_PB_GET 8'h61
`define ATM_PB_RETRY 8'h6c
`define ATM_PB_NULL 8'h60
`define ATM_INS_GR 8'hc0
`define ATM_CLA_GR 8'h00
`define ATM_SW_OK 16'h9000
`define ATM_SW_WARN1 8'h62
`define ATM_SW_WARN2 8'h63
`define ATM_SW_APP 4'h9
`define ATM_SW_FALLBACK 16'h6f00
`define ATM_LEN_FULL 9'h100
`define ATM_FIFO_DEPTH 8
`define ATM_IFS 32
`endif

// file: rtl/atm_pkg.sv
package atm_pkg;
	typedef enum logic [1:0] {ATM_C1 = 2'h0, ATM_C2 = 2'h1, ATM_C3 = 2'h2, ATM_C4 = 2'h3} atm_case_t;
	typedef enum logic [6:0] {
		CS_IDLE = 7'h01, CS_ASK = 7'h02, CS_DIN = 7'h04, CS_DOUT = 7'h08,
		CS_SW1 = 7'h10, CS_SW2 = 7'h20, CS_PB1 = 7'h40
	} atm_card_st_t;
	typedef enum logic [7:0] {
		TS_IDLE = 8'h01, TS_HDR = 8'h02, TS_PB = 8'h04, TS_XX = 8'h08,
		TS_DOUT = 8'h10, TS_DIN = 8'h20, TS_T1TX = 8'h40, TS_T1RX = 8'h80
	} atm_term_st_t;
endpackage : atm_pkg

// file: rtl/atm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface atm_link_if;
	logic [7:0] t2c_data;
	logic t2c_valid;
	logic t2c_ready;
	logic t2c_last;
	logic t2c_more;
	logic [7:0] c2t_data;
	logic c2t_valid;
	logic c2t_ready;
	logic c2t_last;
	logic c2t_more;
	logic t1_mode;
	modport term (output t2c_data, t2c_valid, t2c_last, t2c_more, t1_mode, c2t_ready,
		input t2c_ready, c2t_data, c2t_valid, c2t_last, c2t_more);
	modport card (input t2c_data, t2c_valid, t2c_last, t2c_more, t1_mode, c2t_ready,
		output t2c_ready, c2t_data, c2t_valid, c2t_last, c2t_more);
endinterface : atm_link_if
`default_nettype wire

// file: rtl/atm_term.sv
`timescale 1ns/1ps
`default_nettype none
`include "atm_consts.svh"

module atm_term #(
	parameter int IFS = `ATM_IFS
) (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	atm_link_if.term link, // to card
	input wire logic req, // start command
	input wire logic req_t1, // use T=1
	input wire atm_pkg::atm_case_t req_case, // command case
	input wire logic [31:0] req_hdr, // cla ins p1 p2
	input wire logic [7:0] req_lc, // command data length
	input wire logic [8:0] req_le, // expected length, 256 max
	input wire logic [7:0] wd_data, // command data
	input wire logic wd_valid, // command data valid
	output logic wd_ready, // command data taken
	output logic [7:0] rsp_data, // response byte
	output logic rsp_dv, // response strobe
	output logic [15:0] rsp_sw, // final status
	output logic rsp_done, // command finished
	output logic busy // command in progress
);
	import atm_pkg::*;
	typedef struct packed {
		atm_term_st_t st;
		logic t1;
		logic [39:0] hb;
		atm_case_t cs;
		logic [7:0] lc;
		logic [8:0] le;
		logic [8:0] cnt;
		logic [8:0] pos;
		logic [8:0] rem;
		logic [8:0] bc;
		logic [2:0] hc;
		logic sent;
		logic grp;
		logic [7:0] sw1;
		logic [15:0] q;
		logic [1:0] qn;
		logic [7:0] tx;
		logic txv;
		logic txl;
		logic txm;
		logic [7:0] rd;
		logic rdv;
		logic [15:0] sw;
		logic done;
	} atm_term_t;
	atm_term_t s_reg, s_next;
	logic free, blk_end, hasdat;

	assign free = !s_reg.txv || link.t2c_ready;
	assign blk_end = s_reg.bc == 9'(IFS - 1);
	assign hasdat = s_reg.cs == ATM_C3 || s_reg.cs == ATM_C4;
	assign wd_ready = free && ((s_reg.st == TS_DOUT) || (s_reg.st == TS_T1TX && hasdat &&
		s_reg.pos > 9'h004 && s_reg.pos <= 9'h004 + {1'b0, s_reg.lc}));
	assign link.t2c_data = s_reg.tx;
	assign link.t2c_valid = s_reg.txv;
	assign link.t2c_last = s_reg.txl;
	assign link.t2c_more = s_reg.txm;
	assign link.t1_mode = s_reg.t1;
	assign link.c2t_ready = s_reg.st == TS_PB || s_reg.st == TS_XX ||
		s_reg.st == TS_DIN || s_reg.st == TS_T1RX;
	assign rsp_data = s_reg.rd;
	assign rsp_dv = s_reg.rdv;
	assign rsp_sw = s_reg.sw;
	assign rsp_done = s_reg.done;
	assign busy = s_reg.st != TS_IDLE;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic load;
		logic [7:0] b, d;
		logic [15:0] nq;
		load = 1'b0;
		b = 8'h00;
		d = link.c2t_data;
		nq = {s_reg.q[7:0], d};
		s_next = s_reg;
		s_next.rdv = 1'b0;
		s_next.done = 1'b0;
		if (s_reg.txv && link.t2c_ready)
			s_next.txv = 1'b0;
		case (s_reg.st)
			TS_IDLE: begin
				if (req) begin
					s_next.t1 = req_t1;
					s_next.cs = req_case;
					s_next.lc = req_lc;
					s_next.le = req_le;
					s_next.sent = 1'b0;
					s_next.grp = 1'b0;
					s_next.hc = 3'h0;
					case (req_case)
						ATM_C2: s_next.hb = {req_hdr, req_le[7:0]};
						ATM_C3, ATM_C4: s_next.hb = {req_hdr, req_lc};
						default: s_next.hb = {req_hdr, 8'h00};
					endcase
					if (req_t1) begin
						s_next.pos = 9'h000;
						s_next.bc = 9'h000;
						s_next.rem = 9'h004 +
							((req_case == ATM_C3 || req_case == ATM_C4) ? {1'b0, req_lc} + 9'h001 : 9'h000) +
							((req_case == ATM_C2 || req_case == ATM_C4) ? 9'h001 : 9'h000);
						s_next.st = TS_T1TX;
					end else
						s_next.st = TS_HDR;
				end
			end
			TS_HDR: begin
				if (free) begin
					load = 1'b1;
					b = s_reg.hb[8 * (3'h4 - s_reg.hc) +: 8];
					s_next.hc = s_reg.hc + 3'h1;
					if (s_reg.hc == 3'h4)
						s_next.st = TS_PB;
				end
			end
			TS_PB: begin
				if (link.c2t_valid) begin
					if (d == s_reg.hb[31:24]) begin
						s_next.cnt = (s_reg.hb[7:0] == 8'h00) ? `ATM_LEN_FULL : {1'b0, s_reg.hb[7:0]};
						if (hasdat && !s_reg.grp && !s_reg.sent) begin
							s_next.cnt = {1'b0, s_reg.lc};
							s_next.st = TS_DOUT;
						end else
							s_next.st = TS_DIN;
					end else if (d != `ATM_PB_NULL) begin
						s_next.sw1 = d;
						s_next.st = TS_XX;
					end
				end
			end
			TS_XX: begin
				if (link.c2t_valid) begin
					s_next.hc = 3'h0;
					s_next.st = TS_HDR;
					if (s_reg.sw1 == `ATM_PB_RETRY)
						s_next.hb[7:0] = d;
					else if (s_reg.sw1 == `ATM_PB_GET) begin
						s_next.hb = {`ATM_CLA_GR, `ATM_INS_GR, 16'h0000, d};
						s_next.grp = 1'b1;
					end else if (s_reg.cs == ATM_C4 && s_reg.sent && !s_reg.grp &&
						(s_reg.sw1 == `ATM_SW_WARN1 || s_reg.sw1 == `ATM_SW_WARN2 ||
						(s_reg.sw1[7:4] == `ATM_SW_APP && nq != `ATM_SW_OK))) begin
						s_next.hb = {`ATM_CLA_GR, `ATM_INS_GR, 24'h000000};
						s_next.grp = 1'b1;
					end else begin
						s_next.sw = {s_reg.sw1, d};
						s_next.done = 1'b1;
						s_next.st = TS_IDLE;
					end
				end
			end
			TS_DOUT: begin
				if (wd_valid && wd_ready) begin
					load = 1'b1;
					b = wd_data;
					s_next.cnt = s_reg.cnt - 9'h001;
					if (s_reg.cnt == 9'h001) begin
						s_next.sent = 1'b1;
						s_next.st = TS_PB;
					end
				end
			end
			TS_DIN: begin
				if (link.c2t_valid) begin
					s_next.rd = d;
					s_next.rdv = 1'b1;
					s_next.cnt = s_reg.cnt - 9'h001;
					if (s_reg.cnt == 9'h001)
						s_next.st = TS_PB;
				end
			end
			TS_T1TX: begin
				if (free) begin
					if (s_reg.pos < 9'h004) begin
						load = 1'b1;
						b = s_reg.hb[8 * (3'h4 - s_reg.pos[2:0]) +: 8];
					end else if (hasdat && s_reg.pos == 9'h004) begin
						load = 1'b1;
						b = s_reg.lc;
					end else if (wd_ready)
						load = wd_valid;
					else
						load = 1'b1;
					b = (wd_ready) ? wd_data : (hasdat && s_reg.pos == 9'h004) ? s_reg.lc :
						(s_reg.pos < 9'h004) ? b : s_reg.le[7:0];
				end
				if (load) begin
					s_next.txl = blk_end || s_reg.rem == 9'h001;
					s_next.txm = blk_end && s_reg.rem != 9'h001;
					s_next.bc = blk_end ? 9'h000 : s_reg.bc + 9'h001;
					s_next.pos = s_reg.pos + 9'h001;
					s_next.rem = s_reg.rem - 9'h001;
					if (s_reg.rem == 9'h001) begin
						s_next.qn = 2'h0;
						s_next.st = TS_T1RX;
					end
				end
			end
			TS_T1RX: begin
				if (link.c2t_valid) begin
					s_next.q = nq;
					if (s_reg.qn == 2'h2) begin
						s_next.rd = s_reg.q[15:8];
						s_next.rdv = 1'b1;
					end else
						s_next.qn = s_reg.qn + 2'h1;
					if (link.c2t_last && !link.c2t_more) begin
						s_next.sw = nq;
						s_next.done = 1'b1;
						s_next.st = TS_IDLE;
					end
				end
			end
			default: s_next.st = TS_IDLE;
		endcase
		if (load) begin
			s_next.tx = b;
			s_next.txv = 1'b1;
			if (!s_reg.t1) begin
				s_next.txl = 1'b0;
				s_next.txm = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.st <= TS_IDLE;
			s_reg.cs <= ATM_C1;
		end else
			s_reg <= s_next;
	end
endmodule : atm_term
`default_nettype wire

// file: sim/atm_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module atm_link_chk #(
	parameter int IFS = 32
) (
	input wire logic clk, // clock
	input wire logic reset, // sync reset
	input wire logic [7:0] t2c_data, // terminal byte
	input wire logic t2c_valid, // terminal valid
	input wire logic t2c_ready, // card ready
	input wire logic t2c_last, // block end
	input wire logic t2c_more, // block chained
	input wire logic [7:0] c2t_data, // card byte
	input wire logic c2t_valid, // card valid
	input wire logic c2t_ready, // terminal ready
	input wire logic c2t_last, // block end
	input wire logic c2t_more, // block chained
	input wire logic t1_mode // block protocol
);
	typedef struct packed {
		logic [8:0] tn;
		logic [8:0] cn;
	} atm_chk_st_t;
	atm_chk_st_t st_reg, st_next;

	// bytes already sent in the current block, per direction
	always_comb begin
		st_next = st_reg;
		if (!t1_mode) begin
			st_next = '0;
		end else begin
			if (t2c_valid && t2c_ready) st_next.tn = t2c_last ? 9'h000 : st_reg.tn + 9'h001;
			if (c2t_valid && c2t_ready) st_next.cn = c2t_last ? 9'h000 : st_reg.cn + 9'h001;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) st_reg <= '0;
		else st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_T2C_HOLD: assert property (t2c_valid && !t2c_ready |=> t2c_valid && $stable(t2c_data))
		else $error("t2c byte not held until taken");
	AST_C2T_HOLD: assert property (c2t_valid && !c2t_ready |=>
		c2t_valid && $stable({c2t_data, c2t_last, c2t_more}))
		else $error("c2t byte not held until taken");
	AST_T0_NO_FRAME: assert property (!t1_mode |-> !(t2c_valid && t2c_last) && !(c2t_valid && c2t_last))
		else $error("block end flagged in byte mode");
	AST_MODE_HOLD: assert property (t2c_valid && $past(t2c_valid) |-> $stable(t1_mode))
		else $error("protocol mode changed mid transfer");
	AST_T2C_CHAIN: assert property (t1_mode && t2c_valid && t2c_last && t2c_more |-> int'(st_reg.tn) == IFS - 1)
		else $error("chained terminal block not full size");
	AST_T2C_SIZE: assert property (t1_mode && t2c_valid |-> int'(st_reg.tn) < IFS)
		else $error("terminal block too long");
	AST_C2T_SIZE: assert property (t1_mode && c2t_valid |-> int'(st_reg.cn) < IFS)
		else $error("card block too long");
	AST_IDLE_AFTER_RESET: assert property ($fell(reset) |-> !t2c_valid && !c2t_valid && t2c_ready)
		else $error("link not idle after reset");
endmodule : atm_link_chk
`default_nettype wire

// file: sim/apdu_transport_mapper_test.sv
`timescale 1ns/1ps
`default_nettype none
module apdu_transport_mapper_test;
	import atm_pkg::*;
	localparam int IFS = 4;
	logic clk, reset, req, req_t1, wd_valid, wd_ready, rsp_dv, rsp_done, busy;
	logic cmd_rdy, cmd_dv, app_go, app_ok, rd_valid, rd_ready, done;
	logic rdy_ev, done_ev, rd_take, wd_take;
	atm_case_t req_case, app_case;
	logic [31:0] req_hdr;
	logic [39:0] cmd_hdr;
	logic [7:0] req_lc, wd_data, rsp_data, cmd_data, rd_data, p3e;
	logic [8:0] req_le, app_luicc;
	logic [15:0] rsp_sw, app_sw;
	int n_mismatch, n_compared, n_rdy, n_done, k, np, wi, lcq;
	logic [7:0] eq[$], cq[$], rq[$], wq[$], tq[$], lq[$];
	// t1, case, lc, le, luicc, status, normal
	int tab[15][7] = '{
		'{0, 0, 0, 0, 1, 16'h9000, 1},
		'{0, 1, 0, 5, 5, 16'h9000, 1},
		'{0, 1, 0, 256, 256, 16'h9000, 1},
		'{0, 1, 0, 256, 6, 16'h9000, 1},
		'{0, 1, 0, 9, 4, 16'h9000, 1},
		'{0, 2, 3, 0, 1, 16'h9000, 1},
		'{0, 2, 2, 0, 1, 16'h6a82, 0},
		'{0, 3, 4, 12, 12, 16'h9000, 1},
		'{0, 3, 3, 5, 5, 16'h6283, 0},
		'{1, 0, 0, 0, 1, 16'h9000, 1},
		'{1, 1, 0, 10, 10, 16'h9000, 1},
		'{1, 2, 9, 0, 1, 16'h9000, 1},
		'{1, 3, 5, 6, 6, 16'h6310, 1},
		'{1, 1, 0, 6, 6, 16'h6a82, 1},
		'{1, 3, 2, 3, 3, 16'h91a0, 1}
	};

	atm_link_if atm_link_if_inst ();
	atm_term #(.IFS(IFS)) atm_term_inst (.clk(clk), .reset(reset), .link(atm_link_if_inst),
		.req(req), .req_t1(req_t1), .req_case(req_case), .req_hdr(req_hdr), .req_lc(req_lc),
		.req_le(req_le), .wd_data(wd_data), .wd_valid(wd_valid), .wd_ready(wd_ready),
		.rsp_data(rsp_data), .rsp_dv(rsp_dv), .rsp_sw(rsp_sw), .rsp_done(rsp_done), .busy(busy));
	atm_card #(.IFS(IFS)) atm_card_inst (.clk(clk), .reset(reset), .link(atm_link_if_inst),
		.cmd_rdy(cmd_rdy), .cmd_hdr(cmd_hdr), .cmd_data(cmd_data), .cmd_dv(cmd_dv),
		.app_go(app_go), .app_case(app_case), .app_luicc(app_luicc), .app_sw(app_sw),
		.app_ok(app_ok), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .done(done));
	atm_link_chk #(.IFS(IFS)) atm_link_chk_inst (.clk(clk), .reset(reset),
		.t2c_data(atm_link_if_inst.t2c_data), .t2c_valid(atm_link_if_inst.t2c_valid),
		.t2c_ready(atm_link_if_inst.t2c_ready), .t2c_last(atm_link_if_inst.t2c_last),
		.t2c_more(atm_link_if_inst.t2c_more), .c2t_data(atm_link_if_inst.c2t_data),
		.c2t_valid(atm_link_if_inst.c2t_valid), .c2t_ready(atm_link_if_inst.c2t_ready),
		.c2t_last(atm_link_if_inst.c2t_last), .c2t_more(atm_link_if_inst.c2t_more),
		.t1_mode(atm_link_if_inst.t1_mode));

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// link traffic, results and card requests seen at each rising edge
	always @(posedge clk) begin
		if (!reset) begin
			rd_take = rd_valid && rd_ready;
			wd_take = wd_valid && wd_ready;
			if (atm_link_if_inst.t2c_valid && atm_link_if_inst.t2c_ready)
				tq.push_back(atm_link_if_inst.t2c_data);
			if (atm_link_if_inst.c2t_valid && atm_link_if_inst.c2t_ready)
				lq.push_back(atm_link_if_inst.c2t_data);
			if (done === 1'b1) n_done++;
			if (rsp_dv === 1'b1) chk("rsp_data", eq.size() ? eq.pop_front() : 8'hxx, rsp_data);
			if (cmd_dv === 1'b1) chk("cmd_data", cq.size() ? cq.pop_front() : 8'hxx, cmd_data);
			if (rsp_done === 1'b1) begin
				chk("rsp_sw", app_sw, rsp_sw);
				done_ev = 1;
			end
			if (cmd_rdy === 1'b1) begin
				if (!req_t1) chk("cmd_hdr", {req_hdr, n_rdy ? app_luicc[7:0] : p3e}, cmd_hdr);
				n_rdy++;
				rdy_ev = 1;
			end
		end
	end

	// application answer, response data push and command data stream
	always @(negedge clk) begin
		if (rdy_ev) begin
			rdy_ev = 0;
			app_go = 1;
			k = 0;
		end else begin
			app_go = 0;
			if (rd_take) k++;
		end
		rd_valid = k < np;
		rd_data = k < np ? rq[k] : 8'h00;
		if (wd_take) wi++;
		wd_valid = wi < lcq;
		wd_data = wi < lcq ? wq[wi] : 8'h00;
	end

	task automatic run(input int r[7]);
		logic [31:0] h;
		int i, dat;
		k = 512;
		h = {8'h00, 8'ha4, 16'($urandom)};
		eq.delete(); cq.delete(); rq.delete(); wq.delete(); tq.delete(); lq.delete();
		for (i = 0; i < r[4]; i++) rq.push_back(8'($urandom));
		for (i = 0; i < r[2]; i++) wq.push_back(8'($urandom));
		dat = r[1][0] && (r[0] ? (r[5][15:12] == 9 || r[5][15:9] == 7'h31) : r[6]);
		if (dat) eq = rq;
		np = dat ? r[4] : (r[0] && r[1][0]) ? (r[4] > 8 ? 8 : r[4]) : 0;
		if (r[0]) begin
			for (i = 3; i >= 0; i--) cq.push_back(h[i*8+:8]);
			if (r[1] > 1) cq.push_back(8'(r[2]));
		end
		if (r[0] || r[6]) foreach (wq[j]) cq.push_back(wq[j]);
		if (r[0] && r[1][0]) cq.push_back(8'(r[3]));
		p3e = r[1] > 1 ? 8'(r[2]) : 8'(r[3]);
		@(negedge clk);
		req_t1 = r[0][0];
		req_case = atm_case_t'(r[1][1:0]);
		req_hdr = h;
		req_lc = 8'(r[2]);
		req_le = 9'(r[3]);
		app_case = atm_case_t'(r[1][1:0]);
		app_luicc = 9'(r[4]);
		app_sw = 16'(r[5]);
		app_ok = r[6][0];
		n_rdy = 0;
		n_done = 0;
		k = 512;
		wi = 0;
		lcq = r[2];
		req = 1;
		@(negedge clk);
		req = 0;
		chk("busy", 40'h1, 40'(busy));
		for (i = 0; i < 4000 && !done_ev; i++) @(negedge clk);
		chk("done", 40'h1, 40'(done_ev));
		chk("busy_end", 40'h0, 40'(busy));
		chk("card_done", 40'h1, 40'(n_done));
		done_ev = 0;
		chk("rsp_left", 40'h0, 40'(eq.size()));
		chk("cmd_left", 40'h0, 40'(cq.size()));
		chk("wd_taken", 40'(r[0] || r[6] ? r[2] : 0), 40'(wi));
		if (!r[0] && r[1] == 3 && r[6]) begin
			chk("pb61", {8'h61, 8'(r[4])}, {lq[1], lq[2]});
			chk("gr_hdr", {8'hc0, 8'(r[4])}, {tq[r[2]+6], tq[r[2]+9]});
		end
		if (!r[0] && r[1] == 1 && r[3] > r[4])
			chk("retry", {8'h6c, 8'(r[4]), 8'(r[4])}, {lq[0], lq[1], tq[9]});
	endtask : run

	initial begin
		reset = 1; req = 0; req_t1 = 0; req_case = ATM_C1; req_hdr = 32'h0;
		req_lc = 8'h00; req_le = 9'h000; wd_data = 8'h00; wd_valid = 0; app_go = 0;
		app_case = ATM_C1; app_luicc = 9'h001; app_sw = 16'h0; app_ok = 0; rd_data = 8'h00;
		rd_valid = 0; rdy_ev = 0; done_ev = 0; rd_take = 0; wd_take = 0; p3e = 8'h00;
		n_mismatch = 0; n_compared = 0; n_rdy = 0; n_done = 0; k = 512; np = 0; wi = 0; lcq = 0;
		void'($urandom(37));
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 0;
		for (int i = 0; i < 15; i++) run(tab[i]);
		give_verdict();
	end

	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		$display("[ERR] watchdog exp done got hang");
		give_verdict();
	end
endmodule : apdu_transport_mapper_test
`default_nettype wire
